// *** rtl/fbp_params.svh ***
/*
 * Register offsets, field positions, reset values, codes and timing counts
 * of the fieldbus process-data and parameter-channel block.
 * Assumes inclusion by its bare name from package and design files.
 */
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

`define FBP_OFF_CTRL 12'h000
`define FBP_OFF_WAIT 12'h004
`define FBP_OFF_CYCTO 12'h008
`define FBP_OFF_DELAY 12'h00c
`define FBP_OFF_RXSEL_LO 12'h010
`define FBP_OFF_RXSEL_HI 12'h014
`define FBP_OFF_TXSEL_LO 12'h018
`define FBP_OFF_TXSEL_HI 12'h01c
`define FBP_OFF_STATUS 12'h020
`define FBP_OFF_CMDREF 12'h024

`define FBP_CTRL_EN 0
`define FBP_CTRL_FREEZE 1
`define FBP_CTRL_PROF_LSB 2
`define FBP_CTRL_ACT_LSB 5
`define FBP_ST_LINK 0
`define FBP_ST_ALARM 1
`define FBP_ST_HOLD 2
`define FBP_ST_SELERR 3

`define FBP_RST_WAIT 10'h001
`define FBP_RST_CYCTO 10'h00a
`define FBP_RST_DELAY 10'h000
`define FBP_TIME_MAX 10'h3e8

`define FBP_TICK_CYC 250000

`define FBP_CMD_VALID_BIT 10
`define FBP_OP_RD_INT 16'h0001
`define FBP_OP_RD_FLT 16'h0002
`define FBP_OP_WR_INT 16'h0003
`define FBP_OP_WR_FLT 16'h0004
`define FBP_OP_ERR_BIT 15
`define FBP_ERR_BAD_OP 16'h0003

`endif

// *** rtl/fbp_pkg.sv ***
/*
 * Types shared by the fieldbus block: message carriers, parameter-store
 * request and response, the link state enum and the state record of fbp_param_unit.
 * Assumes fbp_params.svh for the constants.
 */
package fbp_pkg;

    typedef struct packed {
        logic [15:0] param_opcode_word;
        logic [15:0] param_id_word;
        logic [15:0] param_value_high_word;
        logic [15:0] param_value_low_word;
    } fbp_pkw_type;

    // word 0 first: pkw, command, reference, eight configurable words
    typedef struct packed {
        fbp_pkw_type pkw;
        logic [15:0] cmd;
        logic [15:0] ref_word;
        logic [7:0][15:0] conf;
    } fbp_rx_msg_type;

    typedef struct packed {
        fbp_pkw_type pkw;
        logic [15:0] status;
        logic [15:0] speed_fb;
        logic [7:0][15:0] conf;
    } fbp_tx_msg_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic is_float;
        logic [15:0] id;
        logic [31:0] wdata;
    } fbp_cfg_req_type;

    // err is 0 on success, else the reply error code
    typedef struct packed {
        logic [15:0] err;
        logic [31:0] rdata;
    } fbp_cfg_rsp_type;

    typedef enum logic [1:0] {LINK_ACTIVE, LINK_LOST, LINK_RESTORE}
        fbp_link_type;
    typedef enum logic {PU_IDLE, PU_BUSY} fbp_pu_state_type;

    typedef struct packed {
        fbp_pu_state_type state;
        fbp_pkw_type last;
        fbp_pkw_type cur;
        fbp_pkw_type reply;
        fbp_cfg_req_type req;
        logic commit;
    } fbp_pu_type;

endpackage

// *** rtl/fbp_param_unit.sv ***
/*
 * Four-word parameter channel: decodes a request, runs one access on the
 * configuration store and builds the reply words.
 * Assumes a store that holds cfg_req until it answers with a one-cycle
 * cfg_ack, and that treats cfg_commit as a persist order.
 */
`timescale 1ns/1ps
`include "fbp_params.svh"

module fbp_param_unit
    import fbp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the cyclic message
    input wire logic req_valid,
    input fbp_pkw_type req,
    output fbp_pkw_type reply,
    // configuration store
    output fbp_cfg_req_type cfg_req,
    input wire logic cfg_ack,
    input fbp_cfg_rsp_type cfg_rsp,
    output logic cfg_commit
);

    fbp_pu_type s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.commit = 1'b0;
        unique case (s_reg.state)
            PU_IDLE: begin
                // RULE_20: drop retries
                if (req_valid && req.param_opcode_word != 16'h0000 &&
                    req != s_reg.last) begin
                    s_next.last = req;
                    s_next.cur = req;
                    if (req.param_opcode_word >= `FBP_OP_RD_INT &&
                        req.param_opcode_word <= `FBP_OP_WR_FLT) begin
                        // RULE_12: opcode decode
                        s_next.req.valid = 1'b1;
                        s_next.req.write =
                            req.param_opcode_word >= `FBP_OP_WR_INT;
                        s_next.req.is_float = ~req.param_opcode_word[0];
                        // RULE_13: parameter id
                        s_next.req.id = req.param_id_word;
                        // RULE_14: value halves
                        s_next.req.wdata = s_next.req.write ? req[31:0] :
                            32'h0000_0000;
                        s_next.state = PU_BUSY;
                    end else begin
                        // RULE_16: unknown operation reply
                        s_next.reply = {req[63:32], `FBP_ERR_BAD_OP, 16'h0};
                        s_next.reply.param_opcode_word[`FBP_OP_ERR_BIT] = 1'b1;
                    end
                end
            end
            PU_BUSY: begin
                if (cfg_ack) begin
                    s_next.req.valid = 1'b0;
                    s_next.state = PU_IDLE;
                    // RULE_19: echo opcode and id
                    s_next.reply = {s_reg.cur[63:32], cfg_rsp.rdata};
                    if (cfg_rsp.err != 16'h0000) begin
                        // RULE_17: store error code
                        s_next.reply = {s_reg.cur[63:32], cfg_rsp.err, 16'h0};
                        s_next.reply.param_opcode_word[`FBP_OP_ERR_BIT] = 1'b1;
                    end else if (s_reg.req.write) begin
                        // RULE_15: persist write
                        s_next.commit = 1'b1;
                        s_next.reply = s_reg.cur;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reply = s_reg.reply;
    assign cfg_req = s_reg.req;
    assign cfg_commit = s_reg.commit;

endmodule

// *** rtl/fbp_top.sv ***
/*
 * Fieldbus process-data handler: maps received and sent cyclic words,
 * scales analogue words, supervises link loss and serves the parameter
 * channel through fbp_param_unit. Registers sit on an APB slave.
 * Assumes rx_valid pulses once per received cyclic message, synchronous
 * to pclk, and that drive-side inputs are synchronous too.
 */
// Our own choices: the register offsets and the APB slave port.
// Function
// RULE_01: eight received words each pick a meaning by selection code
// RULE_02: speed, analogue-output and regulator words span minus to plus 2 pu
// RULE_03: torque words span minus to plus 4 pu
// RULE_04: each sent word loads any one-word-sized internal item
// RULE_05: restore waiting time programmable 0.01 s to 10 s, default 0.01 s
// RULE_06: waiting time expiry raises alarm; a setting picks the response
// RULE_07: freeze holds command word and reference during the wait
// RULE_08: cycle timeout declares the link inactive and engages freeze
// RULE_09: with freeze, new command/reference taken only if bit 10 set
// RULE_10: after restore, stored values kept for a programmable delay
// RULE_11: parameter channel only in profiles 1, 2, 5, four words each way
// RULE_12: opcode 1/2 read integer/float, 3/4 write integer/float
// RULE_13: second request word names the parameter
// RULE_14: master puts value high half in word three, low in four
// RULE_15: parameter writes persist with no extra command
// RULE_16: refused request sets reply top bit, error code in word three
// RULE_17: errors 2 unknown, 3 bad opcode, 4 read-only, 7 buffer, 10 range
// RULE_18: master repeats a request until its reply arrives
// RULE_19: success echoes opcode and id, read value high then low
// RULE_20: a repeated identical request is served only once
`timescale 1ns/1ps
`include "fbp_params.svh"

module fbp_top
    import fbp_pkg::*;
#(
    parameter int TICK_CYCLES = `FBP_TICK_CYC
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cyclic messages
    input wire logic rx_valid,
    input fbp_rx_msg_type rx_msg,
    output logic tx_valid,
    output fbp_tx_msg_type tx_msg,
    // drive-side process data
    input wire logic [15:0] status_word,
    input wire logic [15:0] speed_fb,
    input wire logic [31:0][15:0] pd_items,
    input wire logic [31:0] pd_word_sized,
    // applied commands and references, link state and alarm
    output logic [15:0] cmd_word,
    output logic [15:0] speed_ref,
    output logic [15:0][17:0] dest,
    output logic link_active,
    output logic fb_alarm,
    output logic [1:0] alarm_action,
    // configuration store
    output fbp_cfg_req_type cfg_req,
    input wire logic cfg_ack,
    input fbp_cfg_rsp_type cfg_rsp,
    output logic cfg_commit
);

    typedef struct packed {
        logic en;
        logic freeze_en;
        logic [2:0] profile;
        logic [1:0] action;
        logic [9:0] wait_time;
        logic [9:0] cyc_to;
        logic [9:0] delay;
        logic [7:0][7:0] rx_sel;
        logic [7:0][7:0] tx_sel;
        logic [17:0] tick_cnt;
        logic tick;
        logic [9:0] idle_cnt;
        logic [9:0] wait_cnt;
        logic [9:0] dly_cnt;
        fbp_link_type link;
        logic link_act;
        logic alarm;
        logic sel_err;
        logic [15:0] cmd;
        logic [15:0] ref_word;
        logic [15:0][17:0] dest;
        logic tx_valid;
        fbp_tx_msg_type tx;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fbp_top_state_type;

    fbp_top_state_type s_reg, s_next;
    fbp_pkw_type pkw_reply;
    logic pkw_go;

    // destination slot: bit 4 valid, bits 3:0 index
    function automatic logic [4:0] dest_of(input logic [7:0] code);
        case (code) inside
            [8'h01:8'h09]: dest_of = {1'b1, 4'(code - 8'h01)};
            8'h15: dest_of = 5'h19;
            8'h0c: dest_of = 5'h1a;
            8'h0d: dest_of = 5'h1b;
            [8'h41:8'h44]: dest_of = {1'b1, 4'(code - 8'h35)};
            default: dest_of = 5'h00;
        endcase
    endfunction

    function automatic logic [3:0] conf_words(input logic [2:0] prof);
        case (prof)
            3'h2, 3'h4: conf_words = 4'h4;
            3'h5: conf_words = 4'h8;
            default: conf_words = 4'h0;
        endcase
    endfunction

    function automatic logic has_pkw(input logic [2:0] prof);
        has_pkw = prof == 3'h1 || prof == 3'h2 || prof == 3'h5;
    endfunction

    function automatic logic [9:0] clamp_time(input logic [31:0] v,
                                              input logic [9:0] lo);
        clamp_time = v < 32'(lo) ? lo :
            v > 32'(`FBP_TIME_MAX) ? `FBP_TIME_MAX : v[9:0];
    endfunction

    // RULE_11: channel gated by profile
    assign pkw_go = rx_valid && s_reg.en && has_pkw(s_reg.profile);

    fbp_param_unit u_param (
        .pclk(pclk),
        .presetn(presetn),
        .req_valid(pkw_go),
        .req(rx_msg.pkw),
        .reply(pkw_reply),
        .cfg_req(cfg_req),
        .cfg_ack(cfg_ack),
        .cfg_rsp(cfg_rsp),
        .cfg_commit(cfg_commit)
    );

    always_comb begin
        logic msg, setup, wr, apply;
        logic [4:0] d, item;
        logic [3:0] nconf;
        s_next = s_reg;
        msg = rx_valid && s_reg.en;
        setup = psel && !penable;
        wr = psel && penable && s_reg.pready && pwrite;
        d = 5'h00;
        item = 5'h00;
        nconf = conf_words(s_reg.profile);
        // status clears come first, so a set further down wins
        if (wr && paddr == `FBP_OFF_STATUS) begin
            s_next.alarm = s_reg.alarm && !pwdata[`FBP_ST_ALARM];
            s_next.sel_err = s_reg.sel_err && !pwdata[`FBP_ST_SELERR];
        end
        s_next.tx_valid = 1'b0;

        // 10 ms time base for all link supervision times
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt == 18'(TICK_CYCLES - 1)) begin
            s_next.tick_cnt = 18'h00000;
            s_next.tick = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 18'h00001;
        end

        if (msg) begin
            s_next.idle_cnt = 10'h000;
        end else if (s_reg.tick && s_reg.idle_cnt != `FBP_TIME_MAX) begin
            s_next.idle_cnt = s_reg.idle_cnt + 10'h001;
        end

        unique case (s_reg.link)
            LINK_ACTIVE: begin
                // RULE_08: cycle timeout
                if (s_reg.en && !msg && s_reg.idle_cnt >= s_reg.cyc_to) begin
                    s_next.link = LINK_LOST;
                    s_next.wait_cnt = 10'h000;
                    // without freeze the drive drops the lost command
                    if (!s_reg.freeze_en) begin
                        s_next.cmd = 16'h0000;
                        s_next.ref_word = 16'h0000;
                    end
                end
            end
            LINK_LOST: begin
                if (msg) begin
                    // RULE_10: restore delay start
                    s_next.link = (s_reg.delay == 10'h000) ?
                        LINK_ACTIVE : LINK_RESTORE;
                    s_next.dly_cnt = 10'h000;
                end else if (s_reg.tick) begin
                    if (s_reg.wait_cnt != `FBP_TIME_MAX) begin
                        s_next.wait_cnt = s_reg.wait_cnt + 10'h001;
                    end
                    // RULE_05: programmable wait expiry
                    // RULE_06: fieldbus alarm
                    if (s_reg.en && s_next.wait_cnt >= s_reg.wait_time) begin
                        s_next.alarm = 1'b1;
                    end
                end
            end
            LINK_RESTORE: begin
                if (!msg && s_reg.idle_cnt >= s_reg.cyc_to) begin
                    s_next.link = LINK_LOST;
                    s_next.wait_cnt = 10'h000;
                end else if (s_reg.tick) begin
                    s_next.dly_cnt = s_reg.dly_cnt + 10'h001;
                    if (s_next.dly_cnt >= s_reg.delay) begin
                        s_next.link = LINK_ACTIVE;
                    end
                end
            end
            default: begin
                s_next.link = LINK_LOST;
            end
        endcase
        if (!s_reg.en) begin
            s_next.link = LINK_LOST;
            s_next.wait_cnt = 10'h000;
        end
        s_next.link_act = s_next.link == LINK_ACTIVE;

        // RULE_07: hold outside active link
        // RULE_10: hold during restore delay
        apply = msg && s_next.link == LINK_ACTIVE;
        // RULE_09: bit 10 validates frozen words
        if (apply && (!s_reg.freeze_en ||
                      rx_msg.cmd[`FBP_CMD_VALID_BIT])) begin
            s_next.cmd = rx_msg.cmd;
            s_next.ref_word = rx_msg.ref_word;
        end

        for (int w = 0; w < 8; w++) begin
            d = dest_of(s_reg.rx_sel[w]);
            // RULE_01: selection code mapping
            if (apply && 4'(w) < nconf) begin
                if (!d[4] && s_reg.rx_sel[w] != 8'h00) begin
                    s_next.sel_err = 1'b1;
                end else if (d[4] && d[3:0] >= 4'h6 && d[3:0] <= 4'h9) begin
                    // RULE_03: 4 pu words doubled to 2 pu grid
                    s_next.dest[d[3:0]] =
                        {rx_msg.conf[w][15], rx_msg.conf[w], 1'b0};
                end else if (d[4]) begin
                    // RULE_02: 2 pu words sign-extended
                    s_next.dest[d[3:0]] =
                        {{2{rx_msg.conf[w][15]}}, rx_msg.conf[w]};
                end
            end
        end

        // sent message answers each received one while enabled
        if (msg) begin
            s_next.tx_valid = 1'b1;
            s_next.tx.pkw = has_pkw(s_reg.profile) ? pkw_reply : '0;
            s_next.tx.status = status_word;
            s_next.tx.speed_fb = speed_fb;
            for (int w = 0; w < 8; w++) begin
                item = s_reg.tx_sel[w][4:0];
                s_next.tx.conf[w] = 16'h0000;
                // RULE_04: word-sized items only
                if (4'(w) < nconf && pd_word_sized[item]) begin
                    s_next.tx.conf[w] = pd_items[item];
                end else if (4'(w) < nconf) begin
                    s_next.sel_err = 1'b1;
                end
            end
        end

        // apb: answer in the first access cycle
        s_next.pready = setup;
        s_next.pslverr = 1'b0;
        s_next.prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            unique case (paddr)
                `FBP_OFF_CTRL: s_next.prdata[6:0] = {s_reg.action,
                    s_reg.profile, s_reg.freeze_en, s_reg.en};
                `FBP_OFF_WAIT: s_next.prdata[9:0] = s_reg.wait_time;
                `FBP_OFF_CYCTO: s_next.prdata[9:0] = s_reg.cyc_to;
                `FBP_OFF_DELAY: s_next.prdata[9:0] = s_reg.delay;
                `FBP_OFF_RXSEL_LO: s_next.prdata = s_reg.rx_sel[3:0];
                `FBP_OFF_RXSEL_HI: s_next.prdata = s_reg.rx_sel[7:4];
                `FBP_OFF_TXSEL_LO: s_next.prdata = s_reg.tx_sel[3:0];
                `FBP_OFF_TXSEL_HI: s_next.prdata = s_reg.tx_sel[7:4];
                `FBP_OFF_STATUS: begin
                    s_next.prdata[`FBP_ST_LINK] = s_reg.link == LINK_ACTIVE;
                    s_next.prdata[`FBP_ST_ALARM] = s_reg.alarm;
                    s_next.prdata[`FBP_ST_HOLD] = s_reg.link != LINK_ACTIVE;
                    s_next.prdata[`FBP_ST_SELERR] = s_reg.sel_err;
                end
                `FBP_OFF_CMDREF: s_next.prdata = {s_reg.ref_word, s_reg.cmd};
                default: s_next.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            s_next.pslverr = paddr > `FBP_OFF_STATUS || paddr[1:0] != 2'h0;
        end

        if (wr) begin
            unique case (paddr)
                `FBP_OFF_CTRL: begin
                    s_next.en = pwdata[`FBP_CTRL_EN];
                    s_next.freeze_en = pwdata[`FBP_CTRL_FREEZE];
                    s_next.profile = pwdata[`FBP_CTRL_PROF_LSB +: 3];
                    // RULE_06: alarm response select
                    s_next.action = pwdata[`FBP_CTRL_ACT_LSB +: 2];
                end
                `FBP_OFF_WAIT: s_next.wait_time = clamp_time(pwdata, 10'h001);
                `FBP_OFF_CYCTO: s_next.cyc_to = clamp_time(pwdata, 10'h001);
                `FBP_OFF_DELAY: s_next.delay = clamp_time(pwdata, 10'h000);
                `FBP_OFF_RXSEL_LO: s_next.rx_sel[3:0] = pwdata;
                `FBP_OFF_RXSEL_HI: s_next.rx_sel[7:4] = pwdata;
                `FBP_OFF_TXSEL_LO: s_next.tx_sel[3:0] = pwdata;
                `FBP_OFF_TXSEL_HI: s_next.tx_sel[7:4] = pwdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.link <= LINK_LOST;
            s_reg.wait_time <= `FBP_RST_WAIT;
            s_reg.cyc_to <= `FBP_RST_CYCTO;
            s_reg.delay <= `FBP_RST_DELAY;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign tx_valid = s_reg.tx_valid;
    assign tx_msg = s_reg.tx;
    assign cmd_word = s_reg.cmd;
    assign speed_ref = s_reg.ref_word;
    assign dest = s_reg.dest;
    assign link_active = s_reg.link_act;
    assign fb_alarm = s_reg.alarm;
    assign alarm_action = s_reg.action;

endmodule

// *** dv/fbp_top_props.sv ***
/* checker for fbp_top ports; bound onto every fbp_top */
`timescale 1ns/1ps
module fbp_top_props
    import fbp_pkg::*;
(
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // link and store
    input wire logic rx_valid,
    input wire logic tx_valid,
    input fbp_tx_msg_type tx_msg,
    input fbp_cfg_req_type cfg_req,
    input wire logic cfg_commit,
    input wire logic [15:0] cmd_word,
    input wire logic fb_alarm,
    input wire logic link_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_free_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    tx_per_rx_a: assert property (tx_valid |-> $past(rx_valid))
        else $error("tx without rx");
    req_from_rx_a: assert property (
        $rose(cfg_req.valid) |-> $past(rx_valid)) else $error("req alone");
    commit_write_a: assert property (
        cfg_commit |-> $past(cfg_req.valid && cfg_req.write))
        else $error("commit without write");
    commit_once_a: assert property (cfg_commit |=> !cfg_commit)
        else $error("double commit");
    hold_lost_a: assert property (
        !link_active && $past(!link_active) |-> $stable(cmd_word))
        else $error("cmd moved while lost");
    alarm_lost_a: assert property ($rose(fb_alarm) |-> !link_active)
        else $error("alarm while active");
    err_code_a: assert property (
        tx_valid && tx_msg.pkw.param_opcode_word[15] |->
        tx_msg.pkw.param_value_high_word inside {2, 3, 4, 7, 10})
        else $error("bad error code");
endmodule
bind fbp_top fbp_top_props i_props (.*);

// *** dv/fbp_store_model.sv ***
/* config store model: ids above 0x200 unknown, 0x200 read-only.
   assumes fbp_top holds cfg_req until one cfg_ack pulse */
`timescale 1ns/1ps
module fbp_store_model
    import fbp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // store port, slow stretches the answer
    input wire logic slow,
    input fbp_cfg_req_type cfg_req,
    output logic cfg_ack,
    output fbp_cfg_rsp_type cfg_rsp
);
    logic [2:0] cnt;
    logic [15:0] err;
    assign err = cfg_req.id == 16'h0200 && cfg_req.write ? 16'h4 :
        cfg_req.id > 16'h0200 ? 16'h2 : 16'h0;
    // junk outside the ack cycle catches a late sample
    assign cfg_rsp = cfg_ack ? {err, cfg_req.id, ~cfg_req.id} : '1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
            cfg_ack <= 1'b0;
        end else begin
            cnt <= cfg_req.valid && !cfg_ack ? cnt + 3'h1 : 3'h0;
            cfg_ack <= cfg_req.valid && !cfg_ack && cnt == {slow, 2'h0};
        end
    end
endmodule

// *** dv/fbp_top_bench.sv ***
/* bench for fbp_top: apb master, cyclic master frames, store model.
   assumes fbp_params.svh on the include path */
`timescale 1ns/1ps
`include "fbp_params.svh"
module fbp_top_bench
    import fbp_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic rx_valid = 0, slow = 0, pready, pslverr, tx_valid, link_active;
    logic fb_alarm, cfg_ack, cfg_commit, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, w_seen = 0, pd_word_sized = '1;
    logic [15:0] status_word = 16'h5a5a, speed_fb = 16'h0102;
    logic [15:0] cmd_word, speed_ref;
    logic [31:0][15:0] pd_items = 512'h1234 << 48;
    logic [15:0][17:0] dest;
    logic [1:0] alarm_action;
    fbp_rx_msg_type rx_msg = 224'h8000_8000;
    fbp_tx_msg_type tx_msg;
    fbp_cfg_req_type cfg_req;
    fbp_cfg_rsp_type cfg_rsp;
    int failures = 0, checks_done = 0, ncommit = 0;
    fbp_top #(.TICK_CYCLES(4)) i_dut (.*);
    fbp_store_model i_store (.*);
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (cfg_commit === 1'b1) ncommit++;
        if (cfg_ack === 1'b1 && cfg_req.write === 1'b1) w_seen <= cfg_req.wdata;
    end
    task automatic chk(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task tmo(input string what);
        chk(what, 1'b0, 1'b1);
        complete_run();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) tmo("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic frame(input logic [15:0] cmd, input fbp_pkw_type pk);
        rx_msg.cmd <= cmd;
        rx_msg.ref_word <= ~cmd;
        rx_msg.pkw <= pk;
        rx_valid <= 1'b1;
        @(posedge pclk);
        rx_valid <= 1'b0;
        @(posedge pclk);
    endtask
    // master repeats until the reply, then once more, then opcode 0
    task automatic pkt(input fbp_pkw_type rq, exp);
        int n;
        slow <= ~slow;
        for (n = 0; n < 20 && tx_msg.pkw !== exp; n++) frame(16'h0405, rq);
        if (n == 20) tmo("reply");
        chk("reply", tx_msg.pkw, exp);
        frame(16'h0405, rq);
        frame(16'h0405, '0);
    endtask
    task t_regs;
        apb(1'b0, `FBP_OFF_WAIT, 32'h0);
        chk("wait", rd, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", er, 1'b1);
        wr(`FBP_OFF_CMDREF, 32'h1);
        chk("readonly", er, 1'b1);
        $display("test registers done");
    endtask
    task t_pd;
        wr(`FBP_OFF_CTRL, 32'h37);
        chk("action", alarm_action, 2'h1);
        wr(`FBP_OFF_CYCTO, 32'h2);
        wr(`FBP_OFF_RXSEL_LO, 32'h701);
        wr(`FBP_OFF_TXSEL_LO, 32'h3);
        frame(16'h0401, '0);
        chk("ref", {cmd_word, speed_ref}, 32'h0401fbfe);
        chk("speed", dest[0], 18'h38000);
        chk("torque", dest[6], 18'h30000);
        chk("txword", tx_msg.conf[0], 16'h1234);
        chk("txfix", {tx_msg.status, tx_msg.speed_fb}, 32'h5a5a0102);
        frame(16'h0002, '0);
        chk("hold", cmd_word, 16'h0401);
        $display("test process data done");
    endtask
    task t_loss;
        int n;
        wr(`FBP_OFF_DELAY, 32'h2);
        wr(`FBP_OFF_STATUS, 32'h2);
        for (n = 0; n < 99 && link_active !== 1'b0; n++) @(posedge pclk);
        if (n == 99) tmo("lost");
        for (n = 0; n < 99 && fb_alarm !== 1'b1; n++) @(posedge pclk);
        if (n == 99) tmo("alarm");
        chk("freeze", cmd_word, 16'h0401);
        wr(`FBP_OFF_CYCTO, 32'h14);
        frame(16'h0405, '0);
        chk("delay", cmd_word, 16'h0401);
        for (n = 0; n < 99 && link_active !== 1'b1; n++) @(posedge pclk);
        if (n == 99) tmo("restore");
        frame(16'h0405, '0);
        chk("resume", cmd_word, 16'h0405);
        $display("test link loss done");
    endtask
    task t_par;
        pkt({16'h3, 16'h5, 32'habcd1234}, {16'h3, 16'h5, 32'habcd1234});
        chk("wdata", w_seen, 32'habcd1234);
        pkt({16'h1, 16'h6, 32'h0}, {16'h1, 16'h6, 32'h0006fff9});
        pkt({16'h2, 16'h6, 32'h0}, {16'h2, 16'h6, 32'h0006fff9});
        pkt({16'h4, 16'h200, 32'h1}, {16'h8004, 16'h200, 32'h40000});
        pkt({16'h3, 16'h300, 32'h1}, {16'h8003, 16'h300, 32'h20000});
        pkt({16'h9, 16'h6, 32'h0}, {16'h8009, 16'h6, 32'h30000});
        chk("commits", ncommit, 64'h1);
        $display("test parameter channel done");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_pd();
        t_loss();
        t_par();
        complete_run();
    end
endmodule
